// [pkg/cawd_pkg.sv]
// constants for the counter array watchdog: register addresses, field positions, reset values
// assumes an 8-bit special function register port driven by the cpu core
package cawd_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'hd8;
  localparam logic [7:0] ADDR_MODE = 8'hd9;
  localparam logic [7:0] ADDR_COUNTER_LOW = 8'he9;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hf9;
  localparam logic [7:0] ADDR_MODULE_FOUR_MODE = 8'hde;
  localparam logic [7:0] ADDR_MODULE_FOUR_OFFSET = 8'hfe;
  localparam logic [7:0] ADDR_MODULE_FOUR_HIGH_COMPARE = 8'hff;

  // control/status field positions
  localparam int CS_OVERFLOW_FLAG = 7;
  localparam int CS_COUNTER_RUN = 6;
  localparam int CS_MODULE_FOUR_MATCH = 4;

  // mode register field positions
  localparam int MD_IDLE_SUSPEND = 7;
  localparam int MD_WATCHDOG_ENABLE = 6;
  localparam int MD_WATCHDOG_LOCK = 5;
  localparam int MD_CLOCK_SOURCE_LSB = 1;
  localparam int MD_OVERFLOW_IRQ_ENABLE = 0;

  // module mode register field positions
  localparam int MM_COMPARATOR_ENABLE = 6;
  localparam int MM_MATCH_ENABLE = 3;
  localparam int MM_MATCH_IRQ_ENABLE = 0;

  // values after reset
  localparam logic [7:0] RESET_CONTROL_STATUS = 8'h00;
  localparam logic [7:0] RESET_MODE = 8'h40;
  localparam logic [7:0] RESET_MODULE_MODE = 8'h00;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNTER = 16'h0000;

  // prescaler divide counts for the system clock sources
  localparam logic [3:0] DIVIDE_TWELVE = 4'hc;
  localparam logic [3:0] DIVIDE_FOUR = 4'h4;
  localparam logic [3:0] RESET_DIVIDER = 4'h0;

  typedef enum logic [2:0] {
    cawd_src_div12 = 3'h0,
    cawd_src_div4 = 3'h1,
    cawd_src_timer0 = 3'h2,
    cawd_src_external = 3'h3,
    cawd_src_sysclk = 3'h4,
    cawd_src_osc_div8 = 3'h5
  } cawd_clk_src_t;

endpackage

// [hdl/cawd_flag.sv]
// one sticky status flag: hardware sets it, software writes it
// assumes set and write strobes are synchronous to clock
`timescale 1ns/1ns
`default_nettype none
module cawd_flag (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic set,
  input wire logic write,
  input wire logic write_value,
  output logic q
);
  import cawd_pkg::*;

  // hardware set beats a software clear in the same cycle so no event is lost
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q <= 1'b0;
    end else if (ce) begin
      if (set) begin
        q <= 1'b1;
      end else if (write) begin
        q <= write_value;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/cawd_prescaler.sv]
// array clock prescaler: one tick per array clock, chosen by the clock source field
// assumes timer0_overflow and external_tick are single-cycle pulses on clock
`timescale 1ns/1ns
`default_nettype none
module cawd_prescaler (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire cawd_pkg::cawd_clk_src_t source,
  input wire logic timer0_overflow,
  input wire logic external_tick,
  input wire logic oscillator_tick,
  output logic tick
);
  import cawd_pkg::*;

  logic [3:0] divider;
  logic [3:0] limit;
  logic wrap;

  assign limit = (source == cawd_src_div4) ? DIVIDE_FOUR : DIVIDE_TWELVE;
  assign wrap = (divider == limit - 4'h1);

  // free running so the divide-twelve tick keeps its phase across source changes that avoid divide four
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      divider <= RESET_DIVIDER;
    end else if (ce) begin
      divider <= wrap ? RESET_DIVIDER : divider + 4'h1;
    end
  end

  always_comb begin
    case (source)
      cawd_src_div12: tick = wrap;
      cawd_src_div4: tick = wrap;
      cawd_src_timer0: tick = timer0_overflow;
      cawd_src_external: tick = external_tick;
      cawd_src_sysclk: tick = 1'b1;
      default: tick = oscillator_tick;
    endcase
  end
endmodule
`default_nettype wire

// [hdl/cawd_watchdog.sv]
// counter array watchdog: shared 16-bit counter, module four compare/watchdog, control registers
// assumes a cpu special function register port with one-cycle write and read strobes
//
// Operation
// - watchdog on forces the counter to run
// - watchdog on blocks counter byte writes
// - watchdog on freezes clock source, idle suspend
// - watchdog on forces module four software timer
// - watchdog on blocks module four mode writes
// - run bit writes cannot stop watchdog counter
// - run bit reads back software value only
// - with watchdog on, high compare write loads counter high plus offset
// - reset on low overflow with high match
// - with watchdog on, writing one to match flag forces reset
// - timeout is offset times 256 plus remainder
// - enable bit or lock bit enables watchdog
// - lock holds enable until reset; else enable clears
// - reset: watchdog on, divide twelve, zero offset
// - idle suspend pauses counter during cpu idle
// - overflow flag sets on wrap, sticky, interrupt
// - run bit stops or runs counter normally
// - match flags set by hardware, never auto-cleared
// - unused control bit reads zero, ignores writes
// - mode register layout and address
// - low compare write clears, high sets comparator enable
`timescale 1ns/1ns
`default_nettype none
module cawd_watchdog (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  input wire logic timer0_overflow,
  input wire logic external_tick,
  input wire logic oscillator_tick,
  input wire logic [3:0] module_match_event,
  input wire logic [3:0] module_irq_enable,
  output logic watchdog_reset,
  output logic array_interrupt
);
  import cawd_pkg::*;

  // register state
  logic counter_run;
  logic idle_suspend;
  logic watchdog_enable;
  logic watchdog_lock;
  cawd_clk_src_t clock_source_select;
  logic overflow_irq_enable;
  logic [7:0] module_four_mode_register;
  logic [7:0] module_four_offset;
  logic [7:0] module_four_high_compare;
  logic [15:0] counter;
  logic counter_overflow_flag;
  logic [4:0] module_match_flag;

  // decode
  logic wr_control;
  logic wr_mode;
  logic wr_low;
  logic wr_high;
  logic wr_module_mode;
  logic wr_offset;
  logic wr_high_compare;

  // datapath
  logic watchdog_on;
  logic array_tick;
  logic counting;
  logic [15:0] next_counter;
  logic low_overflow;
  logic full_overflow;
  logic watchdog_expire;
  logic watchdog_force;
  logic comparator_enable;
  logic match_enable;
  logic module_four_match;
  logic [7:0] next_rdata;

  always_comb begin
    wr_control = 1'b0;
    wr_mode = 1'b0;
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_module_mode = 1'b0;
    wr_offset = 1'b0;
    wr_high_compare = 1'b0;
    if (sfr_write) begin
      if (sfr_addr == ADDR_CONTROL_STATUS) begin
        wr_control = 1'b1;
      end else if (sfr_addr == ADDR_MODE) begin
        wr_mode = 1'b1;
      end else if (sfr_addr == ADDR_COUNTER_LOW) begin
        wr_low = 1'b1;
      end else if (sfr_addr == ADDR_COUNTER_HIGH) begin
        wr_high = 1'b1;
      end else if (sfr_addr == ADDR_MODULE_FOUR_MODE) begin
        wr_module_mode = 1'b1;
      end else if (sfr_addr == ADDR_MODULE_FOUR_OFFSET) begin
        wr_offset = 1'b1;
      end else if (sfr_addr == ADDR_MODULE_FOUR_HIGH_COMPARE) begin
        wr_high_compare = 1'b1;
      end
    end
  end

  assign watchdog_on = watchdog_enable | watchdog_lock;

  cawd_prescaler u_prescaler (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .source(clock_source_select),
    .timer0_overflow(timer0_overflow),
    .external_tick(external_tick),
    .oscillator_tick(oscillator_tick),
    .tick(array_tick)
  );

  // the watchdog overrides the run bit but not the idle suspend, so a suspended
  // watchdog cannot fire while the cpu sleeps
  assign counting = array_tick & (counter_run | watchdog_on)
    & ~(idle_suspend & cpu_idle);
  assign next_counter = counter + 16'h0001;
  assign low_overflow = counting & (counter[7:0] == 8'hff);
  assign full_overflow = low_overflow & (counter[15:8] == 8'hff);

  // timeout counts whole high-byte steps after the first low overflow
  assign watchdog_expire = watchdog_on & low_overflow
    & (counter[15:8] == module_four_high_compare);
  assign watchdog_force = watchdog_on & wr_control & sfr_wdata[CS_MODULE_FOUR_MATCH];

  // module four is a software timer with matching on while the watchdog holds it
  assign comparator_enable = module_four_mode_register[MM_COMPARATOR_ENABLE];
  assign match_enable = watchdog_on | module_four_mode_register[MM_MATCH_ENABLE];
  assign module_four_match = counting & comparator_enable & match_enable
    & (next_counter == {module_four_high_compare, module_four_offset});

  // counter and its byte registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      counter <= RESET_COUNTER;
    end else if (ce) begin
      if (wr_low && !watchdog_on) begin
        counter[7:0] <= sfr_wdata;
      end else if (wr_high && !watchdog_on) begin
        counter[15:8] <= sfr_wdata;
      end else if (counting) begin
        counter <= next_counter;
      end
    end
  end

  // run bit keeps what software wrote, so a forced run does not show in it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      counter_run <= RESET_CONTROL_STATUS[CS_COUNTER_RUN];
    end else if (ce && wr_control) begin
      counter_run <= sfr_wdata[CS_COUNTER_RUN];
    end
  end

  // mode register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      idle_suspend <= RESET_MODE[MD_IDLE_SUSPEND];
      clock_source_select <= cawd_src_div12;
      overflow_irq_enable <= RESET_MODE[MD_OVERFLOW_IRQ_ENABLE];
    end else if (ce && wr_mode) begin
      overflow_irq_enable <= sfr_wdata[MD_OVERFLOW_IRQ_ENABLE];
      if (!watchdog_on) begin
        idle_suspend <= sfr_wdata[MD_IDLE_SUSPEND];
        clock_source_select <= cawd_clk_src_t'(sfr_wdata[MD_CLOCK_SOURCE_LSB +: 3]);
      end
    end
  end

  // the lock only ever sets; it falls only with a system reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      watchdog_enable <= RESET_MODE[MD_WATCHDOG_ENABLE];
      watchdog_lock <= RESET_MODE[MD_WATCHDOG_LOCK];
    end else if (ce && wr_mode) begin
      watchdog_lock <= watchdog_lock | sfr_wdata[MD_WATCHDOG_LOCK];
      if (!watchdog_lock) begin
        watchdog_enable <= sfr_wdata[MD_WATCHDOG_ENABLE];
      end
    end
  end

  // module four mode: blocked under the watchdog, comparator enable follows byte writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      module_four_mode_register <= RESET_MODULE_MODE;
    end else if (ce) begin
      if (wr_module_mode && !watchdog_on) begin
        module_four_mode_register <= sfr_wdata;
      end else if (wr_offset) begin
        module_four_mode_register[MM_COMPARATOR_ENABLE] <= 1'b0;
      end else if (wr_high_compare) begin
        module_four_mode_register[MM_COMPARATOR_ENABLE] <= 1'b1;
      end
    end
  end

  // module four compare bytes; the offset stays writable while the watchdog runs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      module_four_offset <= RESET_BYTE;
      module_four_high_compare <= RESET_BYTE;
    end else if (ce) begin
      if (wr_offset) begin
        module_four_offset <= sfr_wdata;
      end
      if (wr_high_compare) begin
        if (watchdog_on) begin
          // the written value is ignored; this is the watchdog refresh
          module_four_high_compare <= counter[15:8] + module_four_offset;
        end else begin
          module_four_high_compare <= sfr_wdata;
        end
      end
    end
  end

  // sticky status flags
  cawd_flag u_overflow_flag (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .set(full_overflow),
    .write(wr_control),
    .write_value(sfr_wdata[CS_OVERFLOW_FLAG]),
    .q(counter_overflow_flag)
  );

  cawd_flag u_module_four_flag (
    .clock(clock),
    .resetn(resetn),
    .ce(ce),
    .set(module_four_match),
    .write(wr_control),
    .write_value(sfr_wdata[CS_MODULE_FOUR_MATCH]),
    .q(module_match_flag[4])
  );

  // flags of modules zero to three are set by their own compare logic elsewhere
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_flag
      cawd_flag u_flag (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .set(module_match_event[g]),
        .write(wr_control),
        .write_value(sfr_wdata[g]),
        .q(module_match_flag[g])
      );
    end
  endgenerate

  // one-cycle reset request; the reset controller brings every register home
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      watchdog_reset <= 1'b0;
    end else if (ce) begin
      watchdog_reset <= watchdog_expire | watchdog_force;
    end else begin
      watchdog_reset <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      array_interrupt <= 1'b0;
    end else if (ce) begin
      array_interrupt <= (counter_overflow_flag & overflow_irq_enable)
        | (module_match_flag[4] & module_four_mode_register[MM_MATCH_IRQ_ENABLE])
        | (|(module_match_flag[3:0] & module_irq_enable));
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_addr == ADDR_CONTROL_STATUS) begin
      next_rdata = {counter_overflow_flag, counter_run, 1'b0, module_match_flag};
    end else if (sfr_addr == ADDR_MODE) begin
      next_rdata = {idle_suspend, watchdog_enable, watchdog_lock, 1'b0,
        clock_source_select, overflow_irq_enable};
    end else if (sfr_addr == ADDR_COUNTER_LOW) begin
      next_rdata = counter[7:0];
    end else if (sfr_addr == ADDR_COUNTER_HIGH) begin
      next_rdata = counter[15:8];
    end else if (sfr_addr == ADDR_MODULE_FOUR_MODE) begin
      next_rdata = module_four_mode_register;
    end else if (sfr_addr == ADDR_MODULE_FOUR_OFFSET) begin
      next_rdata = module_four_offset;
    end else if (sfr_addr == ADDR_MODULE_FOUR_HIGH_COMPARE) begin
      next_rdata = module_four_high_compare;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= 8'h00;
    end else if (ce && sfr_read) begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// [bench/cawd_watchdog_props.sv]
// port-level checker for the counter array watchdog
// assumes it is bound onto cawd_watchdog; mode and run bits are shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none
module cawd_watchdog_props
  import cawd_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_write,
  input wire logic sfr_read,
  input wire logic [7:0] sfr_rdata,
  input wire logic watchdog_reset
);
  logic wd_on, lock, cr_sw;
  logic [3:0] frz;
  logic wr_md, wr_cs, rd_md, rd_cs;
  assign wr_md = ce && sfr_write && sfr_addr == ADDR_MODE;
  assign wr_cs = ce && sfr_write && sfr_addr == ADDR_CONTROL_STATUS;
  assign rd_md = ce && sfr_read && sfr_addr == ADDR_MODE;
  assign rd_cs = ce && sfr_read && sfr_addr == ADDR_CONTROL_STATUS;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wd_on <= 1'b1;
      lock <= 1'b0;
    end else if (wr_md && !lock) begin
      wd_on <= sfr_wdata[6] | sfr_wdata[5];
      lock <= sfr_wdata[5];
    end
  end
  // frozen fields only take writes made while the watchdog was off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      frz <= 4'h0;
    else if (wr_md && !wd_on)
      frz <= {sfr_wdata[7], sfr_wdata[3:1]};
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn)
      cr_sw <= 1'b0;
    else if (wr_cs)
      cr_sw <= sfr_wdata[6];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_pulse_single: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  chk_force_reset: assert property (wr_cs && sfr_wdata[4] && wd_on |=> watchdog_reset)
    else $error("flag write did not force a watchdog reset");
  chk_reset_needs_on: assert property (watchdog_reset |-> $past(wd_on))
    else $error("watchdog reset while watchdog off");
  chk_unused_zero: assert property (rd_cs |=> sfr_rdata[5] == 1'b0)
    else $error("unused control bit not zero");
  chk_run_readback: assert property (rd_cs |=> sfr_rdata[6] == cr_sw)
    else $error("run bit does not read software value");
  chk_enable_read: assert property (rd_md |=> (sfr_rdata[6] | sfr_rdata[5]) == wd_on)
    else $error("watchdog enable state wrong");
  chk_lock_sticky: assert property (rd_md && lock |=> sfr_rdata[5])
    else $error("lock bit lost");
  chk_mode_frozen: assert property (rd_md |=> {sfr_rdata[7], sfr_rdata[3:1]} == frz)
    else $error("frozen mode fields changed");
  chk_mode_spare: assert property (rd_md |=> sfr_rdata[4] == 1'b0)
    else $error("spare mode bit not zero");
  cover property (watchdog_reset);
  cover property (wr_cs && sfr_wdata[4] && wd_on);
  cover property (rd_md && lock);
endmodule
bind cawd_watchdog cawd_watchdog_props u_cawd_watchdog_props (
  .clock(clock), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
  .watchdog_reset(watchdog_reset));
`default_nettype wire

// [bench/cawd_cpu_model.sv]
// cpu core model: single special function register reads and writes
// assumes the block samples strobes on the rising edge; drives on the falling edge
`timescale 1ns/1ns
`default_nettype none
module cawd_cpu_model (
  input wire logic clock,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_write,
  output logic sfr_read
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_write = 1'b0;
    sfr_read = 1'b0;
  end
  // an idle bus shows inverted values so stale data never passes for a match
  task automatic release_bus();
    sfr_write = 1'b0;
    sfr_read = 1'b0;
    sfr_addr = ~sfr_addr;
    sfr_wdata = ~sfr_wdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1'b1;
    @(negedge clock);
    release_bus();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_read = 1'b1;
    @(negedge clock);
    d = sfr_rdata;
    release_bus();
  endtask
endmodule
`default_nettype wire

// [bench/cawd_watchdog_tb.sv]
// self-checking bench for the counter array watchdog
// assumes the cpu model owns the register port; the bench plays the reset controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); \
  end \
end
module cawd_watchdog_tb;
  import cawd_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cpu_idle = 1'b0;
  logic [3:0] match_ev = 4'h0;
  logic [3:0] irq_en = 4'h0;
  logic ce = 1'b1;
  logic ext = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, v, w;
  logic sfr_write, sfr_read, watchdog_reset, array_interrupt;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, seed, to;
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  cawd_watchdog u_cawd_watchdog (
    .clock(clock), .resetn(resetn), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
    .timer0_overflow(1'b0), .external_tick(ext), .oscillator_tick(1'b0),
    .module_match_event(match_ev), .module_irq_enable(irq_en),
    .watchdog_reset(watchdog_reset), .array_interrupt(array_interrupt));
  cawd_cpu_model u_cawd_cpu_model (
    .clock(clock), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_write(sfr_write), .sfr_read(sfr_read));
  function automatic int to_ticks(input int off, input int low);
    return 256 * off + (256 - low);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cawd_cpu_model.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    u_cawd_cpu_model.rd(a, d);
  endtask
  task automatic do_reset();
    @(negedge clock);
    resetn = 1'b0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    cyc = 0;
  endtask
  // the pulse lasts one cycle, so look before every wait
  task automatic wait_wd(input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (watchdog_reset === 1'b1)
        break;
      @(negedge clock);
    end
    `CHK(i < lim, 1'b1)
  endtask
  task automatic final_report();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    $display("ERROR %0t: run timed out", $time);
    final_report();
  end
  initial begin
    seed = $urandom(32'h5229);
    do_reset();
    rd(ADDR_MODE, v);
    `CHK(v, 8'h40)
    wr(ADDR_CONTROL_STATUS, 8'h20);
    rd(ADDR_CONTROL_STATUS, v);
    `CHK(v & 8'h60, 8'h00)
    wr(ADDR_MODULE_FOUR_MODE, 8'hff);
    rd(ADDR_MODULE_FOUR_MODE, v);
    `CHK(v, 8'h00)
    wr(ADDR_MODE, 8'hce);
    rd(ADDR_MODE, v);
    `CHK(v, 8'h40)
    wr(ADDR_COUNTER_HIGH, 8'h5a);
    rd(ADDR_COUNTER_HIGH, v);
    `CHK(v, 8'h00)
    rd(ADDR_COUNTER_LOW, v);
    repeat (48) @(negedge clock);
    rd(ADDR_COUNTER_LOW, w);
    `CHK(w != v, 1'b1)
    to = 12 * to_ticks(0, 0);
    wait_wd(3200);
    `CHK(cyc inside {[to - 12 : to + 18]}, 1'b1)
    do_reset();
    rd(ADDR_MODE, v);
    `CHK(v, 8'h40)
    wr(ADDR_CONTROL_STATUS, 8'h10);
    wait_wd(3);
    do_reset();
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_MODE, v);
    `CHK(v, 8'h00)
    wr(ADDR_MODE, 8'h08);
    v = 8'($urandom);
    w = 8'($urandom);
    wr(ADDR_COUNTER_LOW, v);
    wr(ADDR_COUNTER_HIGH, w);
    rd(ADDR_COUNTER_LOW, t0[7:0]);
    `CHK(t0[7:0], v)
    rd(ADDR_COUNTER_HIGH, v);
    `CHK(v, w)
    wr(ADDR_MODULE_FOUR_MODE, 8'h48);
    wr(ADDR_MODULE_FOUR_OFFSET, 8'h03);
    rd(ADDR_MODULE_FOUR_MODE, v);
    `CHK(v, 8'h08)
    wr(ADDR_MODULE_FOUR_HIGH_COMPARE, 8'h00);
    rd(ADDR_MODULE_FOUR_MODE, v);
    `CHK(v, 8'h48)
    wr(ADDR_MODULE_FOUR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h88);
    cpu_idle = 1'b1;
    wr(ADDR_CONTROL_STATUS, 8'h40);
    rd(ADDR_COUNTER_LOW, v);
    repeat (5) @(negedge clock);
    rd(ADDR_COUNTER_LOW, w);
    `CHK(w, v)
    cpu_idle = 1'b0;
    rd(ADDR_COUNTER_LOW, w);
    `CHK(w != v, 1'b1)
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'hfc);
    wr(ADDR_COUNTER_HIGH, 8'hff);
    wr(ADDR_CONTROL_STATUS, 8'h40);
    repeat (8) @(negedge clock);
    rd(ADDR_CONTROL_STATUS, v);
    `CHK(v[7], 1'b1)
    repeat (20) @(negedge clock);
    `CHK(array_interrupt, 1'b1)
    wr(ADDR_CONTROL_STATUS, 8'h00);
    wr(ADDR_MODE, 8'h08);
    for (int k = 0; k < 6; k++) begin
      w = (k == 0) ? 8'h0f : 8'($urandom);
      irq_en = (k == 0) ? 4'h0 : 4'($urandom);
      match_ev = w[3:0];
      @(negedge clock);
      match_ev = 4'h0;
      repeat (3) @(negedge clock);
      rd(ADDR_CONTROL_STATUS, v);
      `CHK(v[3:0], w[3:0])
      `CHK(array_interrupt, |(w[3:0] & irq_en))
      wr(ADDR_CONTROL_STATUS, 8'h00);
      rd(ADDR_CONTROL_STATUS, v);
      `CHK(v, 8'h00)
    end
    // module four as a plain software timer: match at 0x0010 sets its flag
    wr(ADDR_MODULE_FOUR_MODE, 8'h08);
    wr(ADDR_MODULE_FOUR_OFFSET, 8'h10);
    wr(ADDR_MODULE_FOUR_HIGH_COMPARE, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h0c);
    wr(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'h40);
    repeat (8) @(negedge clock);
    rd(ADDR_CONTROL_STATUS, v);
    `CHK(v[4], 1'b1)
    // clock enable low must freeze the running counter
    rd(ADDR_COUNTER_LOW, v);
    ce = 1'b0;
    repeat (20) @(negedge clock);
    ce = 1'b1;
    rd(ADDR_COUNTER_LOW, w);
    `CHK(w, v + 8'h02)
    // external source: the counter steps once per external pulse
    wr(ADDR_MODE, 8'h06);
    rd(ADDR_COUNTER_LOW, v);
    for (int k = 0; k < 5; k++) begin
      ext = 1'b1;
      @(negedge clock);
      ext = 1'b0;
      @(negedge clock);
    end
    rd(ADDR_COUNTER_LOW, w);
    `CHK(w, v + 8'h05)
    wr(ADDR_CONTROL_STATUS, 8'h00);
    wr(ADDR_COUNTER_LOW, 8'h80);
    wr(ADDR_COUNTER_HIGH, 8'h00);
    wr(ADDR_MODULE_FOUR_OFFSET, 8'h02);
    wr(ADDR_MODE, 8'h28);
    wr(ADDR_MODULE_FOUR_HIGH_COMPARE, 8'h77);
    t0 = cyc;
    rd(ADDR_MODULE_FOUR_HIGH_COMPARE, v);
    `CHK(v, 8'h02)
    wr(ADDR_MODE, 8'h00);
    rd(ADDR_MODE, v);
    `CHK(v, 8'h28)
    to = to_ticks(2, 8'h80);
    wait_wd(700);
    `CHK((cyc - t0) inside {[to - 10 : to + 4]}, 1'b1)
    do_reset();
    rd(ADDR_MODE, v);
    `CHK(v, 8'h40)
    final_report();
  end
endmodule
`default_nettype wire
